// ### rtl/afh_pkg.sv
/*
 package for the host access port to the async transmit queues and receive fifos.
 assumes classic wishbone with 32-bit data, byte addresses, one clock.
*/
package afh_pkg;
	localparam int AFH_AW = 8;
	localparam int AFH_DW = 32;
	// register byte offsets
	localparam logic [7:0] AFH_TIMER_SELECT_CTRL = 8'h60;
	localparam logic [7:0] AFH_TIMER_OFFSET_LOW_STATUS = 8'h68;
	localparam logic [7:0] AFH_TIMER_PACKET_STATUS = 8'h6c;
	localparam logic [7:0] AFH_TX_HEAD_QUADLET_WRITE = 8'h70;
	localparam logic [7:0] AFH_TX_BODY_QUADLET_WRITE = 8'h74;
	localparam logic [7:0] AFH_TX_TAIL_QUADLET_WRITE = 8'h78;
	localparam logic [7:0] AFH_ASYNC_RX_POP = 8'h80;
	localparam logic [7:0] AFH_MGMT_RX_POP = 8'h84;
	localparam logic [7:0] AFH_CMD_RX_POP = 8'h88;
	localparam logic [7:0] AFH_ROM_SIZE_CONTROL = 8'h8c;
	// reset values
	localparam logic [31:0] AFH_RESET_WORD = 32'h0000_0000;
	localparam logic [3:0] AFH_TIMER_SELECT_RESET = 4'h0;
	// timer_select codes
	localparam logic [3:0] AFH_TMR_DATA_TX = 4'h0;
	localparam logic [3:0] AFH_TMR_DATA_RX = 4'h1;
	localparam logic [3:0] AFH_TMR_MGMT = 4'h2;
	localparam logic [3:0] AFH_TMR_CMD = 4'h4;
	localparam logic [3:0] AFH_TMR_AUTORESP = 4'h6;
	// fields, given as lsb-numbered positions (doc bit n is lsb bit 31-n)
	localparam int AFH_TCODE_LSB = 28;
	localparam int AFH_SPEED_LSB = 26;
	localparam int AFH_TLABEL_LSB = 20;
	localparam int AFH_RETRY_LSB = 16;
	localparam int AFH_WAIT_LSB = 0;
	localparam int AFH_AR_BYTES_LSB = 16;
	localparam int AFH_TOTAL_BYTES_LSB = 0;
	localparam int AFH_TSEL_LSB = 4;
	localparam int AFH_HOLD_BIT = 2;
	localparam int AFH_RELEASE_BIT = 1;
	// transmit queue codes
	localparam logic [1:0] AFH_Q_ASYNC = 2'h0;
	localparam logic [1:0] AFH_Q_MGMT = 2'h1;
	localparam logic [1:0] AFH_Q_CMD = 2'h2;
	// tcode values that steer a head quadlet; labels in the top range go to the command queue
	localparam logic [3:0] AFH_TCODE_PHY = 4'he;
	localparam logic [5:0] AFH_CMD_LABEL_MIN = 6'h30;
	localparam int AFH_RXQ = 3;
	typedef enum logic [1:0] {AFH_IDLE, AFH_ACK} afh_bus_e;
endpackage

// ### rtl/afh_rx_pop.sv
/*
 one receive fifo read port: pops on request, repeats the last quadlet when empty.
 assumes the fifo shows head data while not empty and pops on pop_o.
*/
`timescale 1ns/1ps
module afh_rx_pop (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_reset_i,
	// fifo side
	input wire logic [31:0] fifo_data_i,
	input wire logic fifo_empty_i,
	output logic pop_o,
	// register side
	input wire logic read_i,
	output logic [31:0] quadlet_o
);
	import afh_pkg::*;
	assign pop_o = read_i && !fifo_empty_i;
	// empty keeps the stale value so software sees the last good quadlet
	always_ff @(posedge clk_i) begin
		if (rst_i || bus_reset_i) begin
			quadlet_o <= AFH_RESET_WORD;
		end else if (pop_o) begin
			quadlet_o <= fifo_data_i;
		end
	end
endmodule // afh_rx_pop

// ### rtl/afh_wait_timer.sv
/*
 response wait timer of one transaction: counts cycle-start packets while waiting.
 assumes start and cycle_start are single-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
module afh_wait_timer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_reset_i,
	// events
	input wire logic start_i,
	input wire logic waiting_i,
	input wire logic cycle_start_i,
	// count
	output logic [15:0] count_o
);
	import afh_pkg::*;
	// restart wins; count holds after the wait ends so the last period stays readable
	always_ff @(posedge clk_i) begin
		if (rst_i || bus_reset_i || start_i) begin
			count_o <= 16'h0000;
		end else if (waiting_i && cycle_start_i) begin
			count_o <= count_o + 16'h0001;
		end
	end
endmodule // afh_wait_timer

// ### rtl/afh_port.sv
/*
 host access port: transmit quadlet writes, receive fifo pops, timer status, rom size.
 assumes classic wishbone master on clk_i (40 MHz) and link logic on the same clock.
*/
// Operation
// - status word two returns low destination offset of the selected timer's packet.
// - status word three holds tcode in bits 0-3, speed in 4-5.
// - status word three holds tlabel in bits 6-11, retry limit in 12-15.
// - bits 16-31 hold response wait timer, counting cycle-start packets.
// - head write pushes into a transmit queue chosen by tlabel and tcode.
// - body write appends to the queue chosen by the last head write.
// - tail write appends the last quadlet to that same queue.
// - write and pop registers reset to zero and clear on bus reset.
// - async receive pop returns next quadlet, or last valid when empty.
// - management receive pop returns next quadlet, or last valid when empty.
// - command receive pop returns next quadlet, or last valid when empty.
// - rom size register resets to zero and survives bus reset.
// - bits 6-15 hold autoresponse rom bytes; host keeps it below 228h.
// - bits 21-31 hold total rom bytes; host keeps it below 400h.
// - timer select picks data tx, data rx, mgmt, cmd or autoresponse.
`timescale 1ns/1ps
module afh_port (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_reset_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [afh_pkg::AFH_AW-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [afh_pkg::AFH_DW-1:0] dat_i,
	output logic [afh_pkg::AFH_DW-1:0] dat_o,
	output logic ack_o,
	// transmit queue pushes
	output logic [31:0] tx_data_o,
	output logic [2:0] tx_push_o,
	output logic tx_last_o,
	output logic hold_transmit_o,
	output logic release_transmit_o,
	// receive fifos, index 0 async, 1 mgmt, 2 cmd
	input wire logic [31:0] rx_data_i [afh_pkg::AFH_RXQ],
	input wire logic [2:0] rx_empty_i,
	output logic [2:0] rx_pop_o,
	// transaction status per timer, index is the timer_select code
	input wire logic [31:0] tr_offset_low_i [8],
	input wire logic [3:0] tr_tcode_i [8],
	input wire logic [1:0] tr_speed_i [8],
	input wire logic [5:0] tr_tlabel_i [8],
	input wire logic [3:0] tr_retry_i [8],
	input wire logic [7:0] tr_start_i,
	input wire logic [7:0] tr_waiting_i,
	input wire logic cycle_start_i,
	// rom sizes
	output logic [9:0] autoresp_rom_bytes_o,
	output logic [10:0] total_rom_bytes_o
);
	import afh_pkg::*;

	afh_bus_e state;
	logic [3:0] timer_select;
	logic [1:0] head_queue;
	logic [31:0] tx_head_quadlet_write;
	logic [31:0] tx_body_quadlet_write;
	logic [31:0] tx_tail_quadlet_write;
	logic [9:0] autoresp_rom_bytes;
	logic [10:0] total_rom_bytes;
	logic [31:0] rx_quadlet [AFH_RXQ];
	logic [15:0] response_wait_timer [8];
	logic [2:0] rx_read;
	logic req;
	logic wr;
	logic rd;
	logic [31:0] next_dat;

	// bit 0 of a printed field is the msb of the quadlet
	function automatic logic [1:0] pick_queue(input logic [31:0] q);
		logic [3:0] tcode;
		logic [5:0] tlabel;
		// same lsb positions as the status word, so steering and status agree
		tcode = q[AFH_TCODE_LSB+:4];
		tlabel = q[AFH_TLABEL_LSB+:6];
		if (tcode == AFH_TCODE_PHY) begin
			pick_queue = AFH_Q_MGMT;
		end else if (tlabel >= AFH_CMD_LABEL_MIN) begin
			pick_queue = AFH_Q_CMD;
		end else begin
			pick_queue = AFH_Q_ASYNC;
		end
	endfunction

	function automatic logic [2:0] queue_onehot(input logic [1:0] q);
		queue_onehot = 3'b001 << q;
	endfunction

	// one wait state: ack the cycle after the request is seen, drop it next
	assign req = cyc_i && stb_i && (state == AFH_IDLE);
	assign wr = req && we_i;
	assign rd = req && !we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= AFH_IDLE;
		end else begin
			case (state)
				AFH_IDLE: if (cyc_i && stb_i) state <= AFH_ACK;
				AFH_ACK: state <= AFH_IDLE;
				default: state <= AFH_IDLE;
			endcase
		end
	end
	assign ack_o = (state == AFH_ACK);

	// timer select, hold and release controls
	always_ff @(posedge clk_i) begin
		if (rst_i || bus_reset_i) begin
			timer_select <= AFH_TIMER_SELECT_RESET;
			hold_transmit_o <= 1'b0;
			release_transmit_o <= 1'b0;
		end else begin
			hold_transmit_o <= 1'b0;
			release_transmit_o <= 1'b0;
			if (wr && adr_i == AFH_TIMER_SELECT_CTRL && sel_i == 4'hf) begin
				timer_select <= dat_i[AFH_TSEL_LSB+:4];
				// both set: release wins and the hold is dropped
				hold_transmit_o <= dat_i[AFH_HOLD_BIT] && !dat_i[AFH_RELEASE_BIT];
				release_transmit_o <= dat_i[AFH_RELEASE_BIT];
			end
		end
	end

	// transmit quadlet registers and queue steering
	always_ff @(posedge clk_i) begin
		if (rst_i || bus_reset_i) begin
			tx_head_quadlet_write <= AFH_RESET_WORD;
			tx_body_quadlet_write <= AFH_RESET_WORD;
			tx_tail_quadlet_write <= AFH_RESET_WORD;
			head_queue <= AFH_Q_ASYNC;
			tx_data_o <= AFH_RESET_WORD;
			tx_push_o <= 3'b000;
			tx_last_o <= 1'b0;
		end else begin
			tx_push_o <= 3'b000;
			tx_last_o <= 1'b0;
			if (wr) begin
				case (adr_i)
					AFH_TX_HEAD_QUADLET_WRITE: begin
						tx_head_quadlet_write <= dat_i;
						head_queue <= pick_queue(dat_i);
						tx_data_o <= dat_i;
						tx_push_o <= queue_onehot(pick_queue(dat_i));
					end
					AFH_TX_BODY_QUADLET_WRITE: begin
						tx_body_quadlet_write <= dat_i;
						tx_data_o <= dat_i;
						tx_push_o <= queue_onehot(head_queue);
					end
					AFH_TX_TAIL_QUADLET_WRITE: begin
						tx_tail_quadlet_write <= dat_i;
						tx_data_o <= dat_i;
						tx_push_o <= queue_onehot(head_queue);
						tx_last_o <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// rom size register: only full quadlet writes land, kept over bus reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			autoresp_rom_bytes <= 10'h000;
			total_rom_bytes <= 11'h000;
		end else if (wr && adr_i == AFH_ROM_SIZE_CONTROL && sel_i == 4'hf) begin
			autoresp_rom_bytes <= dat_i[AFH_AR_BYTES_LSB+:10];
			total_rom_bytes <= dat_i[AFH_TOTAL_BYTES_LSB+:11];
		end
	end
	assign autoresp_rom_bytes_o = autoresp_rom_bytes;
	assign total_rom_bytes_o = total_rom_bytes;

	// receive pops, one port per fifo
	assign rx_read[0] = rd && adr_i == AFH_ASYNC_RX_POP;
	assign rx_read[1] = rd && adr_i == AFH_MGMT_RX_POP;
	assign rx_read[2] = rd && adr_i == AFH_CMD_RX_POP;

	genvar gi;
	generate
		for (gi = 0; gi < AFH_RXQ; gi++) begin : g_rx
			afh_rx_pop u_pop (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.bus_reset_i(bus_reset_i),
				.fifo_data_i(rx_data_i[gi]),
				.fifo_empty_i(rx_empty_i[gi]),
				.pop_o(rx_pop_o[gi]),
				.read_i(rx_read[gi]),
				.quadlet_o(rx_quadlet[gi])
			);
		end
		for (gi = 0; gi < 8; gi++) begin : g_tmr
			afh_wait_timer u_tmr (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.bus_reset_i(bus_reset_i),
				.start_i(tr_start_i[gi]),
				.waiting_i(tr_waiting_i[gi]),
				.cycle_start_i(cycle_start_i),
				.count_o(response_wait_timer[gi])
			);
		end
	endgenerate

	// read mux; pop data is the value after the pop, so it is sampled on ack
	always_comb begin
		next_dat = AFH_RESET_WORD;
		case (adr_i)
			AFH_TIMER_SELECT_CTRL: next_dat[AFH_TSEL_LSB+:4] = timer_select;
			AFH_TIMER_OFFSET_LOW_STATUS: next_dat = tr_offset_low_i[timer_select[2:0]];
			AFH_TIMER_PACKET_STATUS: begin
				next_dat[AFH_TCODE_LSB+:4] = tr_tcode_i[timer_select[2:0]];
				next_dat[AFH_SPEED_LSB+:2] = tr_speed_i[timer_select[2:0]];
				next_dat[AFH_TLABEL_LSB+:6] = tr_tlabel_i[timer_select[2:0]];
				next_dat[AFH_RETRY_LSB+:4] = tr_retry_i[timer_select[2:0]];
				next_dat[AFH_WAIT_LSB+:16] = response_wait_timer[timer_select[2:0]];
			end
			AFH_ASYNC_RX_POP: next_dat = rx_quadlet[0];
			AFH_MGMT_RX_POP: next_dat = rx_quadlet[1];
			AFH_CMD_RX_POP: next_dat = rx_quadlet[2];
			AFH_ROM_SIZE_CONTROL: begin
				next_dat[AFH_AR_BYTES_LSB+:10] = autoresp_rom_bytes;
				next_dat[AFH_TOTAL_BYTES_LSB+:11] = total_rom_bytes;
			end
			default: next_dat = AFH_RESET_WORD;
		endcase
		// reserved timer codes read as zero status
		if ((adr_i == AFH_TIMER_OFFSET_LOW_STATUS || adr_i == AFH_TIMER_PACKET_STATUS) &&
			(timer_select == 4'h3 || timer_select == 4'h5 || timer_select[3] || timer_select == 4'h7)) begin
			next_dat = AFH_RESET_WORD;
		end
	end
	assign dat_o = ack_o ? next_dat : AFH_RESET_WORD;
endmodule // afh_port

// ### test/afh_link_model.sv
/*
 link side model: three receive fifos and per-timer transaction status.
 assumes pops arrive as pulses on clk_i; load refills every fifo with two words.
*/
`timescale 1ns/1ps
module afh_link_model (
	// clock and control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	// receive fifos
	input wire logic [2:0] pop_i,
	output logic [31:0] rx_data_o [3],
	output logic [2:0] empty_o,
	// timer status
	output logic [31:0] offs_o [8],
	output logic [3:0] tcode_o [8],
	output logic [1:0] speed_o [8],
	output logic [5:0] label_o [8],
	output logic [3:0] retry_o [8]
);
	logic [1:0] cnt [3];
	always_ff @(posedge clk_i)
		for (int i = 0; i < 3; i++)
			if (rst_i || load_i)
				cnt[i] <= rst_i ? 2'h0 : 2'h2;
			else if (pop_i[i] && cnt[i] != 2'h0)
				cnt[i] <= cnt[i] - 2'h1;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			empty_o[i] = cnt[i] == 2'h0;
			// empty fifo shows junk so a stale head word cannot pass
			rx_data_o[i] = empty_o[i] ? 32'h5a5a_5a5a : {16'ha000, 6'(i), cnt[i], 8'h0};
		end
		for (int k = 0; k < 8; k++) begin
			offs_o[k] = 32'h1234_0000 | 32'(k);
			tcode_o[k] = 4'(k + 1);
			speed_o[k] = 2'(k);
			label_o[k] = 6'(k + 8);
			retry_o[k] = 4'(k);
		end
	end
endmodule // afh_link_model

// ### test/afh_port_chk.sv
/*
 checker for the host access port.
 assumes it sees only the port pins; bound to afh_port below.
*/
`timescale 1ns/1ps
module afh_port_chk
	import afh_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bus_reset_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [31:0] tx_data_o,
	input wire logic [2:0] tx_push_o,
	input wire logic tx_last_o,
	input wire logic [31:0] rx_data_i [3],
	input wire logic [2:0] rx_empty_i,
	input wire logic [2:0] rx_pop_o,
	input wire logic [9:0] autoresp_rom_bytes_o,
	input wire logic [10:0] total_rom_bytes_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic hd_d;
	logic [2:0] last_q;
	// remember the queue picked by the last head push
	always_ff @(posedge clk_i) begin
		hd_d <= !rst_i && cyc_i && stb_i && we_i && !ack_o && adr_i == AFH_TX_HEAD_QUADLET_WRITE;
		if (hd_d)
			last_q <= tx_push_o;
	end
	sequence s_take(a, w);
		cyc_i && stb_i && !ack_o && we_i == w && adr_i == a;
	endsequence
	property p_ack_next;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	property p_idle_zero;
		!ack_o |-> dat_o == 32'h0;
	endproperty
	property p_head;
		s_take(AFH_TX_HEAD_QUADLET_WRITE, 1'h1) |=> $onehot(tx_push_o) && tx_data_o == $past(dat_i) && !tx_last_o;
	endproperty
	property p_body;
		s_take(AFH_TX_BODY_QUADLET_WRITE, 1'h1) |=> tx_push_o == last_q && !tx_last_o;
	endproperty
	property p_tail;
		s_take(AFH_TX_TAIL_QUADLET_WRITE, 1'h1) |=> tx_push_o == last_q && tx_last_o;
	endproperty
	property p_pop;
		s_take(AFH_ASYNC_RX_POP, 1'h0) |-> rx_pop_o[0] == !rx_empty_i[0];
	endproperty
	property p_pop_data;
		s_take(AFH_MGMT_RX_POP, 1'h0) ##0 !rx_empty_i[1] |=> dat_o == $past(rx_data_i[1]);
	endproperty
	property p_rom_keep;
		bus_reset_i && !cyc_i |=> $stable(total_rom_bytes_o) && $stable(autoresp_rom_bytes_o);
	endproperty
	property p_rom_wr;
		s_take(AFH_ROM_SIZE_CONTROL, 1'h1) ##0 sel_i == 4'hf |=>
			total_rom_bytes_o == $past(dat_i[10:0]) && autoresp_rom_bytes_o == $past(dat_i[25:16]);
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside ack");
	a_head: assert property (p_head) else $error("head push wrong");
	a_body: assert property (p_body) else $error("body push to other queue");
	a_tail: assert property (p_tail) else $error("tail push wrong");
	a_pop: assert property (p_pop) else $error("async pop mismatch");
	a_pop_data: assert property (p_pop_data) else $error("mgmt pop data wrong");
	a_rom_keep: assert property (p_rom_keep) else $error("rom size lost on bus reset");
	a_rom_wr: assert property (p_rom_wr) else $error("rom size fields wrong");
endmodule // afh_port_chk
bind afh_port afh_port_chk u_chk (.clk_i, .rst_i, .bus_reset_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
	.dat_o, .ack_o, .tx_data_o, .tx_push_o, .tx_last_o, .rx_data_i, .rx_empty_i, .rx_pop_o,
	.autoresp_rom_bytes_o, .total_rom_bytes_o);

// ### test/test_async_fifo_host_access_port.sv
/*
 bench for the host access port: wishbone tasks, tests as call sequences.
 assumes afh_link_model on the far side and the checker bound to the port.
*/
`timescale 1ns/1ps
module test_async_fifo_host_access_port;
	import afh_pkg::*;
	logic clk_i = 1'h0, rst_i = 1'h1, bus_reset_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
	logic load = 1'h0, cycle_start_i = 1'h0, ack_o, tx_last_o, hold_transmit_o, release_transmit_o, sl, sh, sr;
	logic [7:0] adr_i = '0, tr_start_i = '0, tr_waiting_i = '0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = '0, dat_o, tx_data_o, q, sd;
	logic [2:0] tx_push_o, rx_empty_i, rx_pop_o, sp;
	logic [31:0] rx_data_i [3], offs [8];
	logic [3:0] tcode [8], retry [8];
	logic [1:0] speed [8];
	logic [5:0] label [8];
	logic [9:0] autoresp_rom_bytes_o;
	logic [10:0] total_rom_bytes_o;
	int n_fail = 0, check_count = 0;
	initial forever #12.5 clk_i = ~clk_i;
	afh_port DUT (.clk_i, .rst_i, .bus_reset_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.tx_data_o, .tx_push_o, .tx_last_o, .hold_transmit_o, .release_transmit_o, .rx_data_i, .rx_empty_i,
		.rx_pop_o, .tr_offset_low_i(offs), .tr_tcode_i(tcode), .tr_speed_i(speed), .tr_tlabel_i(label),
		.tr_retry_i(retry), .tr_start_i, .tr_waiting_i, .cycle_start_i, .autoresp_rom_bytes_o, .total_rom_bytes_o);
	afh_link_model u_link (.clk_i, .rst_i, .load_i(load), .pop_i(rx_pop_o), .rx_data_o(rx_data_i),
		.empty_o(rx_empty_i), .offs_o(offs), .tcode_o(tcode), .speed_o(speed), .label_o(label), .retry_o(retry));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one classic cycle; outputs captured at the ack edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1 && n < 40);
		if (n >= 40)
			n_fail++;
		q = dat_o;
		sd = tx_data_o;
		sp = tx_push_o;
		sl = tx_last_o;
		sh = hold_transmit_o;
		sr = release_transmit_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// steering fields placed at both plausible positions
	function automatic logic [31:0] hq(input logic [3:0] t, input logic [5:0] l);
		return {t, 2'h0, l, 4'h0, l, 2'h0, t, 4'h0};
	endfunction
	initial begin
		#50000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		for (int i = 0; i < 4; i++) begin
			wb(1'h0, AFH_ASYNC_RX_POP + 8'(4 * i), '0);
			chk(q, AFH_RESET_WORD, "reset value");
		end
		load <= 1'h1;
		@(posedge clk_i);
		load <= 1'h0;
		for (int i = 0; i < 3; i++)
			for (int k = 2; k >= 0; k--) begin
				wb(1'h0, AFH_ASYNC_RX_POP + 8'(4 * i), '0);
				chk(q, {16'ha000, 6'(i), 2'(k > 0 ? k : 1), 8'h0}, "rx pop");
			end
		wb(1'h1, AFH_ROM_SIZE_CONTROL, 32'h0227_03ff);
		chk(32'(autoresp_rom_bytes_o), 32'h227, "autoresp bytes");
		chk(32'(total_rom_bytes_o), 32'h3ff, "total bytes");
		bus_reset_i <= 1'h1;
		@(posedge clk_i);
		bus_reset_i <= 1'h0;
		@(posedge clk_i);
		wb(1'h0, AFH_ASYNC_RX_POP, '0);
		chk(q, AFH_RESET_WORD, "pop after bus reset");
		wb(1'h0, AFH_ROM_SIZE_CONTROL, '0);
		chk(q, 32'h0227_03ff, "rom size kept");
		sel_i <= 4'h3;
		wb(1'h1, AFH_ROM_SIZE_CONTROL, 32'h0);
		sel_i <= 4'hf;
		wb(1'h0, AFH_ROM_SIZE_CONTROL, '0);
		chk(q, 32'h0227_03ff, "partial rom write ignored");
		for (int j = 0; j < 3; j++) begin
			wb(1'h1, AFH_TIMER_SELECT_CTRL, 32'h4);
			chk(32'(sh), 32'h1, "hold");
			wb(1'h1, AFH_TX_HEAD_QUADLET_WRITE, hq(j == 1 ? 4'he : 4'h1, j == 2 ? 6'h30 : 6'h2f));
			chk(32'(sp), 32'h1 << j, "head queue");
			wb(1'h1, AFH_TX_BODY_QUADLET_WRITE, 32'hb0 + 32'(j));
			chk({sd[27:0], sl, sp}, {28'hb0 + 28'(j), 1'h0, 3'h1 << j}, "body");
			wb(1'h1, AFH_TX_TAIL_QUADLET_WRITE, 32'hc0);
			chk({sd[27:0], sl, sp}, {28'hc0, 1'h1, 3'h1 << j}, "tail");
			wb(1'h1, AFH_TIMER_SELECT_CTRL, 32'h2);
			chk(32'(sr), 32'h1, "release");
		end
		tr_start_i <= 8'hff;
		@(posedge clk_i);
		tr_start_i <= 8'h0;
		tr_waiting_i <= 8'h04;
		repeat (3) begin
			cycle_start_i <= 1'h1;
			@(posedge clk_i);
			cycle_start_i <= 1'h0;
			@(posedge clk_i);
		end
		tr_waiting_i <= 8'h0;
		for (int k = 0; k < 8; k++) begin
			wb(1'h1, AFH_TIMER_SELECT_CTRL, 32'(k << 4));
			wb(1'h0, AFH_TIMER_OFFSET_LOW_STATUS, '0);
			chk(q, (k inside {0, 1, 2, 4, 6}) ? 32'h1234_0000 | 32'(k) : 32'h0, "offset");
			wb(1'h0, AFH_TIMER_PACKET_STATUS, '0);
			chk(q, (k inside {0, 1, 2, 4, 6}) ? {4'(k + 1), 2'(k), 6'(k + 8), 4'(k), 16'(k == 2 ? 3 : 0)} : 32'h0,
				"status");
		end
		wb(1'h0, 8'h7c, '0);
		chk(q, 32'h0, "unmapped");
		finish_test();
	end
endmodule // test_async_fifo_host_access_port
